// ---- pmic_pin_and_buck_control_regs.v ----
`timescale 1ns/100ps
`include "pmic_ctrl_map.vh"

module pmic_pin_and_buck_control_regs #(
    parameter NPINS = 4,
    parameter NBUCK = 4,
    parameter NLIN = 8
) (
    input wire mclk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [95:0] base_image,
    input wire [11:0] pin123_function_select,
    input wire [8:0] pin123_electrical_mode,
    input wire [2:0] pin123_polarity_flip,
    input wire rtc_on,
    input wire rtc_clk32,
    input wire [3:0] pin_in,
    output reg [3:0] pin_out,
    output reg [3:0] pin_oe,
    output reg pin4_pull_up,
    output reg pin4_pull_down,
    output reg pin4_analog_en,
    output reg [95:0] effective_image,
    output reg [3:0] buck_on,
    output reg [27:0] buck_level_out,
    output reg [7:0] linreg_on,
    output reg [3:0] buck_quiet_mode,
    output reg [3:0] buck_quick_regulation,
    output reg buck3_follower,
    output reg [8:0] buck_freq_mhz
);

    reg [7:0] pin4_config_r;
    reg [3:0] buck_global_on_r;
    reg [3:0] pin_drive_value_r;
    reg [3:0] pin_sensed_level_r;
    reg [7:0] alt_setting_first_r;
    reg [7:0] alt_setting_second_r;
    reg [7:0] alt_setting_third_r;
    reg [7:0] alt_target_selects_r;
    reg [3:0] alt_target_third_r;
    reg [7:0] buck_pin_control_r;
    reg [15:0] linreg_pin_control_r;
    reg [7:0] buck_noise_speed_r;
    reg [7:0] buck_ramp_freq_r;
    reg [11:0] slow_cnt_r;
    reg slow_clk_r;
    reg rtc_meta_r;
    reg rtc_sync_r;
    reg [6:0] ramp_level_r;
    reg [11:0] ramp_cnt_r;

    wire [15:0] pin_function_select;
    wire [11:0] pin_electrical_mode;
    wire [3:0] pin_polarity_flip;
    wire [3:0] pin_level;
    wire [3:0] pin_sensed_nxt;
    wire [3:0] vsel_pin;
    wire vsel_active;
    wire slow_src;
    reg [95:0] effective_nxt;

    // Mode decodes used for every pin.
    function is_drive_mode;
        input [2:0] mode;
        begin
            is_drive_mode = (mode == `MODE_PUSH_PULL) || (mode == `MODE_OPEN_DRAIN) ||
                (mode == `MODE_OD_PULL_UP);
        end
    endfunction

    function is_digital_in;
        input [2:0] mode;
        begin
            is_digital_in = (mode != `MODE_PUSH_PULL) && (mode != `MODE_ANALOG) &&
                (mode != `MODE_ANALOG_PULL_DOWN);
        end
    endfunction

    // Picks the level of pin one to three for a two-bit control code.
    function pin_by_code;
        input [1:0] code;
        input [3:0] levels;
        begin
            pin_by_code = (code == 2'h0) ? 1'b1 : levels[code - 2'h1];
        end
    endfunction

    // Pin four configuration is local, pins one to three arrive from their owners.
    assign pin_function_select = {pin4_config_r[`PIN_FUNC_HI:`PIN_FUNC_LO],
        pin123_function_select};
    assign pin_electrical_mode = {pin4_config_r[`PIN_MODE_HI:`PIN_MODE_LO],
        pin123_electrical_mode};
    assign pin_polarity_flip = {pin4_config_r[`PIN_INVERT_BIT], pin123_polarity_flip};

    // The slow clock comes from the RTC when running, else from the divider.
    assign slow_src = rtc_on ? rtc_sync_r : slow_clk_r;

    // Per-pin input path and voltage-select detection.
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
            wire [3:0] fn = pin_function_select[4*gi+3:4*gi];
            wire [2:0] md = pin_electrical_mode[3*gi+2:3*gi];
            assign pin_level[gi] = pin_in[gi] ^ pin_polarity_flip[gi];
            assign pin_sensed_nxt[gi] = is_digital_in(md) & pin_level[gi];
            assign vsel_pin[gi] = ((fn == `FN_VOLT_SELECT) || (fn == `FN_STANDBY_SELECT)) &&
                is_digital_in(md) && pin_level[gi];
        end
    endgenerate

    assign vsel_active = |vsel_pin;

    // Overlay of the alternate bytes onto the regulator image; third wins, then second.
    integer ri;
    always @* begin
        effective_nxt = base_image;
        for (ri = 0; ri < `REG_COUNT; ri = ri + 1) begin
            if (vsel_active && (alt_target_selects_r[3:0] < `TARGET_LIMIT) &&
                (alt_target_selects_r[3:0] == ri[3:0])) begin
                effective_nxt[8*ri +: 8] = alt_setting_first_r;
            end
            if (vsel_active && (alt_target_selects_r[7:4] < `TARGET_LIMIT) &&
                (alt_target_selects_r[7:4] == ri[3:0])) begin
                effective_nxt[8*ri +: 8] = alt_setting_second_r;
            end
            if (vsel_active && (alt_target_third_r < `TARGET_LIMIT) &&
                (alt_target_third_r == ri[3:0])) begin
                effective_nxt[8*ri +: 8] = alt_setting_third_r;
            end
        end
    end

    // Ramp target code and the step delay chosen by the host.
    wire [1:0] ramp_sel = buck_ramp_freq_r[`RAMP_TARGET_HI:`RAMP_TARGET_LO];
    wire [1:0] ramp_time = buck_ramp_freq_r[`RAMP_TIME_HI:`RAMP_TIME_LO];
    wire [6:0] ramp_goal = effective_nxt[8*ramp_sel +: 7];
    localparam [31:0] STEP1_FULL = `RAMP_STEP1_CYCLES;
    localparam [31:0] STEP2_FULL = `RAMP_STEP2_CYCLES;
    localparam [31:0] STEP3_FULL = `RAMP_STEP3_CYCLES;
    reg [11:0] ramp_period;
    always @* begin
        case (ramp_time)
            2'h1: ramp_period = STEP1_FULL[11:0];
            2'h2: ramp_period = STEP2_FULL[11:0];
            2'h3: ramp_period = STEP3_FULL[11:0];
            default: ramp_period = 12'h001;
        endcase
    end

    // Host register writes; unused bits are dropped.
    always @(posedge mclk) begin
        if (!rst_n) begin
            pin4_config_r <= `RST_PIN4_CONFIG;
            buck_global_on_r <= `RST_BUCK_GLOBAL_ENABLES;
            pin_drive_value_r <= 4'h0;
            alt_setting_first_r <= 8'h00;
            alt_setting_second_r <= 8'h00;
            alt_setting_third_r <= 8'h00;
            alt_target_selects_r <= `RST_ALT_TARGET_SELECTS;
            alt_target_third_r <= `RST_ALT_TARGET_THIRD;
            buck_pin_control_r <= 8'h00;
            linreg_pin_control_r <= 16'h0000;
            buck_noise_speed_r <= 8'h00;
            buck_ramp_freq_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_PIN4_CONFIG) begin
                pin4_config_r <= reg_wdata;
            end else if (reg_addr == `ADDR_BUCK_GLOBAL_ENABLES) begin
                buck_global_on_r <= reg_wdata[3:0];
            end else if (reg_addr == `ADDR_PIN_OUTPUT_IMAGE) begin
                pin_drive_value_r <= reg_wdata[3:0];
            end else if (reg_addr == `ADDR_ALT_SETTING_FIRST) begin
                alt_setting_first_r <= reg_wdata;
            end else if (reg_addr == `ADDR_ALT_SETTING_SECOND) begin
                alt_setting_second_r <= reg_wdata;
            end else if (reg_addr == `ADDR_ALT_TARGET_SELECTS) begin
                alt_target_selects_r <= reg_wdata;
            end else if (reg_addr == `ADDR_BUCK_PIN_CONTROL) begin
                buck_pin_control_r <= reg_wdata;
            end else if (reg_addr == `ADDR_LINREG_PIN_CONTROL_LOW) begin
                linreg_pin_control_r[7:0] <= reg_wdata;
            end else if (reg_addr == `ADDR_LINREG_PIN_CONTROL_HIGH) begin
                linreg_pin_control_r[15:8] <= reg_wdata;
            end else if (reg_addr == `ADDR_ALT_SETTING_THIRD) begin
                alt_setting_third_r <= reg_wdata;
            end else if (reg_addr == `ADDR_ALT_TARGET_THIRD) begin
                alt_target_third_r <= reg_wdata[3:0];
            end else if (reg_addr == `ADDR_BUCK_NOISE_SPEED) begin
                buck_noise_speed_r <= reg_wdata;
            end else if (reg_addr == `ADDR_BUCK_RAMP_FREQ) begin
                buck_ramp_freq_r <= reg_wdata;
            end
        end
    end

    // Host register reads, answered one cycle after the strobe; unmapped reads zero.
    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_PIN4_CONFIG) begin
                reg_rdata <= pin4_config_r;
            end else if (reg_addr == `ADDR_BUCK_GLOBAL_ENABLES) begin
                reg_rdata <= {4'h0, buck_global_on_r};
            end else if (reg_addr == `ADDR_PIN_OUTPUT_IMAGE) begin
                reg_rdata <= {4'h0, pin_drive_value_r};
            end else if (reg_addr == `ADDR_PIN_INPUT_IMAGE) begin
                reg_rdata <= {4'h0, pin_sensed_level_r};
            end else if (reg_addr == `ADDR_ALT_SETTING_FIRST) begin
                reg_rdata <= alt_setting_first_r;
            end else if (reg_addr == `ADDR_ALT_SETTING_SECOND) begin
                reg_rdata <= alt_setting_second_r;
            end else if (reg_addr == `ADDR_ALT_TARGET_SELECTS) begin
                reg_rdata <= alt_target_selects_r;
            end else if (reg_addr == `ADDR_BUCK_PIN_CONTROL) begin
                reg_rdata <= buck_pin_control_r;
            end else if (reg_addr == `ADDR_LINREG_PIN_CONTROL_LOW) begin
                reg_rdata <= linreg_pin_control_r[7:0];
            end else if (reg_addr == `ADDR_LINREG_PIN_CONTROL_HIGH) begin
                reg_rdata <= linreg_pin_control_r[15:8];
            end else if (reg_addr == `ADDR_ALT_SETTING_THIRD) begin
                reg_rdata <= alt_setting_third_r;
            end else if (reg_addr == `ADDR_ALT_TARGET_THIRD) begin
                reg_rdata <= {4'h0, alt_target_third_r};
            end else if (reg_addr == `ADDR_BUCK_NOISE_SPEED) begin
                reg_rdata <= buck_noise_speed_r;
            end else if (reg_addr == `ADDR_BUCK_RAMP_FREQ) begin
                reg_rdata <= buck_ramp_freq_r;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Slow clock divider and the RTC clock synchroniser.
    always @(posedge mclk) begin
        if (!rst_n) begin
            slow_cnt_r <= 12'h000;
            slow_clk_r <= 1'b0;
            rtc_meta_r <= 1'b0;
            rtc_sync_r <= 1'b0;
        end else begin
            rtc_meta_r <= rtc_clk32;
            rtc_sync_r <= rtc_meta_r;
            if (slow_cnt_r == `SLOW_HALF_CYCLES - 1) begin
                slow_cnt_r <= 12'h000;
                slow_clk_r <= ~slow_clk_r;
            end else begin
                slow_cnt_r <= slow_cnt_r + 12'h001;
            end
        end
    end

    // Voltage ramp: the selected buck moves one code per step period; with a ramp time code of zero it jumps straight to its goal.
    always @(posedge mclk) begin
        if (!rst_n) begin
            ramp_level_r <= 7'h00;
            ramp_cnt_r <= 12'h000;
        end else if (ramp_time == 2'h0) begin
            ramp_level_r <= ramp_goal;
            ramp_cnt_r <= 12'h000;
        end else if (ramp_level_r == ramp_goal) begin
            ramp_cnt_r <= 12'h000;
        end else if (ramp_cnt_r >= ramp_period - 12'h001) begin
            ramp_cnt_r <= 12'h000;
            if (ramp_level_r < ramp_goal) begin
                ramp_level_r <= ramp_level_r + 7'h01;
            end else begin
                ramp_level_r <= ramp_level_r - 7'h01;
            end
        end else begin
            ramp_cnt_r <= ramp_cnt_r + 12'h001;
        end
    end

    // Per-buck level code: ramped for the ramp target, buck three may follow buck two.
    integer ci;
    reg [27:0] buck_code_nxt;
    always @* begin
        buck_code_nxt = 28'h0;
        for (ci = 0; ci < NBUCK; ci = ci + 1) begin
            buck_code_nxt[7*ci +: 7] = (ramp_sel == ci[1:0]) ? ramp_level_r :
                effective_nxt[8*ci +: 7];
        end
        if (buck_ramp_freq_r[`FOLLOWER_BIT]) begin
            buck_code_nxt[20:14] = buck_code_nxt[13:7];
        end
    end

    // Registered pin drive, input image and regulator outputs.
    integer bi;
    always @(posedge mclk) begin
        if (!rst_n) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
            pin4_pull_up <= 1'b0;
            pin4_pull_down <= 1'b0;
            pin4_analog_en <= 1'b1;
            pin_sensed_level_r <= 4'h0;
            effective_image <= 96'h0;
            buck_on <= 4'h0;
            buck_level_out <= 28'h0;
            linreg_on <= 8'h00;
            buck_quiet_mode <= 4'h0;
            buck_quick_regulation <= 4'h0;
            buck3_follower <= 1'b0;
            buck_freq_mhz <= 9'h000;
        end else begin
            pin_sensed_level_r <= pin_sensed_nxt;
            effective_image <= effective_nxt;
            for (bi = 0; bi < NPINS; bi = bi + 1) begin
                if (pin_function_select[4*bi +: 4] == `FN_SLOW_CLOCK) begin
                    pin_out[bi] <= slow_src ^ pin_polarity_flip[bi];
                end else begin
                    pin_out[bi] <= pin_drive_value_r[bi] ^ pin_polarity_flip[bi];
                end
                if (pin_electrical_mode[3*bi +: 3] == `MODE_PUSH_PULL) begin
                    pin_oe[bi] <= 1'b1;
                end else if (is_drive_mode(pin_electrical_mode[3*bi +: 3])) begin
                    pin_oe[bi] <= ~(pin_drive_value_r[bi] ^ pin_polarity_flip[bi]);
                end else begin
                    pin_oe[bi] <= 1'b0;
                end
            end
            pin4_pull_up <= (pin_electrical_mode[11:9] == `MODE_IN_PULL_UP) ||
                (pin_electrical_mode[11:9] == `MODE_OD_PULL_UP);
            pin4_pull_down <= (pin_electrical_mode[11:9] == `MODE_IN_PULL_DOWN) ||
                (pin_electrical_mode[11:9] == `MODE_ANALOG_PULL_DOWN);
            pin4_analog_en <= (pin_electrical_mode[11:9] == `MODE_ANALOG) ||
                (pin_electrical_mode[11:9] == `MODE_ANALOG_PULL_DOWN);
            buck_level_out <= buck_code_nxt;
            for (bi = 0; bi < NBUCK; bi = bi + 1) begin
                buck_on[bi] <= buck_global_on_r[bi] && (buck_code_nxt[7*bi +: 7] != 7'h00) &&
                    pin_by_code(buck_pin_control_r[2*bi +: 2], pin_level);
            end
            for (bi = 0; bi < NLIN; bi = bi + 1) begin
                linreg_on[bi] <= effective_nxt[8*(bi+4) + `LINREG_ON_BIT] &&
                    pin_by_code(linreg_pin_control_r[2*bi +: 2], pin_level);
            end
            buck_quiet_mode <= buck_noise_speed_r[7:4];
            buck_quick_regulation <= buck_noise_speed_r[3:0];
            buck3_follower <= buck_ramp_freq_r[`FOLLOWER_BIT];
            for (bi = 0; bi < 3; bi = bi + 1) begin
                if (!effective_nxt[8*bi + `BUCK_PICK_BIT]) begin
                    buck_freq_mhz[3*bi +: 3] <= buck_ramp_freq_r[bi] ? `FREQ_MID : `FREQ_LOW;
                end else begin
                    buck_freq_mhz[3*bi +: 3] <= buck_ramp_freq_r[bi] ? `FREQ_HIGH : `FREQ_MID;
                end
            end
        end
    end

endmodule

// ---- pmic_ctrl_map.vh ----
`ifndef PMIC_CTRL_MAP_VH
`define PMIC_CTRL_MAP_VH

// Register offsets.
`define ADDR_PIN4_CONFIG 8'h0F
`define ADDR_BUCK_GLOBAL_ENABLES 8'h10
`define ADDR_PIN_OUTPUT_IMAGE 8'h20
`define ADDR_PIN_INPUT_IMAGE 8'h21
`define ADDR_ALT_SETTING_FIRST 8'h22
`define ADDR_ALT_SETTING_SECOND 8'h23
`define ADDR_ALT_TARGET_SELECTS 8'h24
`define ADDR_BUCK_PIN_CONTROL 8'h25
`define ADDR_LINREG_PIN_CONTROL_LOW 8'h26
`define ADDR_LINREG_PIN_CONTROL_HIGH 8'h27
`define ADDR_ALT_SETTING_THIRD 8'h2B
`define ADDR_ALT_TARGET_THIRD 8'h2C
`define ADDR_BUCK_NOISE_SPEED 8'h30
`define ADDR_BUCK_RAMP_FREQ 8'h31

// Reset values.
`define RST_PIN4_CONFIG 8'h03
`define RST_BUCK_GLOBAL_ENABLES 4'hF
`define RST_ALT_TARGET_SELECTS 8'hFF
`define RST_ALT_TARGET_THIRD 4'hF

// Field positions.
`define PIN_INVERT_BIT 7
`define PIN_FUNC_HI 6
`define PIN_FUNC_LO 3
`define PIN_MODE_HI 2
`define PIN_MODE_LO 0
`define LINREG_ON_BIT 7
`define BUCK_PICK_BIT 7
`define BUCK_CODE_HI 6
`define RAMP_TARGET_HI 7
`define RAMP_TARGET_LO 6
`define RAMP_TIME_HI 5
`define RAMP_TIME_LO 4
`define FOLLOWER_BIT 3

// Pin functions.
`define FN_PLAIN_IO 4'h0
`define FN_VOLT_SELECT 4'h5
`define FN_STANDBY_SELECT 4'h6
`define FN_SLOW_CLOCK 4'h8

// Pin modes.
`define MODE_INPUT 3'h0
`define MODE_PUSH_PULL 3'h1
`define MODE_OPEN_DRAIN 3'h2
`define MODE_ANALOG 3'h3
`define MODE_IN_PULL_UP 3'h4
`define MODE_IN_PULL_DOWN 3'h5
`define MODE_OD_PULL_UP 3'h6
`define MODE_ANALOG_PULL_DOWN 3'h7

// Alternate setting limits.
`define TARGET_LIMIT 4'hC
`define REG_COUNT 12

// Timing.
`define CLK_HZ 200000000
`define CLK_PERIOD_NS 5
`define SLOW_CLK_HZ 32768
`define SLOW_HALF_CYCLES (`CLK_HZ / (2 * `SLOW_CLK_HZ))
`define RAMP_STEP1_NS 4000
`define RAMP_STEP2_NS 8000
`define RAMP_STEP3_NS 16000
`define RAMP_STEP1_CYCLES (`RAMP_STEP1_NS / `CLK_PERIOD_NS)
`define RAMP_STEP2_CYCLES (`RAMP_STEP2_NS / `CLK_PERIOD_NS)
`define RAMP_STEP3_CYCLES (`RAMP_STEP3_NS / `CLK_PERIOD_NS)

// Frequencies in MHz.
`define FREQ_LOW 3'h2
`define FREQ_MID 3'h3
`define FREQ_HIGH 3'h4

`endif

// ---- pmic_regs_chk.sv ----
`timescale 1ns/100ps
// Watches the register port and the registered outputs of the control bank.
module pmic_regs_chk (
    input wire mclk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [3:0] pin_oe,
    input wire [3:0] buck_quiet_mode,
    input wire [3:0] buck_quick_regulation,
    input wire buck3_follower,
    input wire [8:0] buck_freq_mhz
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Mode bits reach their outputs two edges after the write is taken.
    a_quiet_copy: assert property (reg_wr && reg_addr == 8'h30
        |-> ##2 buck_quiet_mode == $past(reg_wdata[7:4], 2)) else $error("Quiet copy wrong.");
    a_quick_copy: assert property (reg_wr && reg_addr == 8'h30
        |-> ##2 buck_quick_regulation == $past(reg_wdata[3:0], 2)) else $error("Quick copy wrong.");
    a_follower_copy: assert property (reg_wr && reg_addr == 8'h31
        |-> ##2 buck3_follower == $past(reg_wdata[3], 2)) else $error("Follower copy wrong.");
    a_push_pull_drive: assert property (reg_wr && reg_addr == 8'h0F && reg_wdata[6:0] == 7'h01
        |-> ##2 pin_oe[3]) else $error("Push-pull pin not driven.");

    // Unused and unmapped places always read back as zero.
    a_enable_unused: assert property (reg_rd && reg_addr == 8'h10
        |=> reg_rdata[7:4] == 4'h0) else $error("Enable upper bits not zero.");
    a_image_unused: assert property (reg_rd && reg_addr == 8'h21
        |=> reg_rdata[7:4] == 4'h0) else $error("Input image upper bits not zero.");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h31
        |=> reg_rdata == 8'h00) else $error("Unmapped read not zero.");
    a_out_image_back: assert property (reg_wr && reg_addr == 8'h20 ##2 reg_rd && reg_addr == 8'h20
        |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)}) else $error("Output image readback wrong.");

    // Bucks one to three each run at 2, 3 or 4 MHz once real logic drives the outputs.
    a_freq_legal: assert property ($past(rst_n) |-> buck_freq_mhz[2:0] inside {3'h2, 3'h3, 3'h4}
        && buck_freq_mhz[5:3] inside {3'h2, 3'h3, 3'h4} && buck_freq_mhz[8:6] inside {3'h2, 3'h3, 3'h4})
        else $error("Illegal buck frequency.");

    c_image_read: cover property (reg_rd && reg_addr == 8'h21);
    c_target_write: cover property (reg_wr && reg_addr == 8'h24);
    c_follower_on: cover property (buck3_follower);
endmodule

bind pmic_pin_and_buck_control_regs pmic_regs_chk chk (.mclk(mclk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_oe(pin_oe), .buck_quiet_mode(buck_quiet_mode),
    .buck_quick_regulation(buck_quick_regulation), .buck3_follower(buck3_follower),
    .buck_freq_mhz(buck_freq_mhz));

// ---- pmic_host_model.sv ----
`timescale 1ns/100ps
// Host side of the register port: one strobe per access, changed on the falling edge.
module pmic_host_model (
    input wire mclk,
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    // Idle bus at time zero.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write; callers pass only defined bits, save one write of 0F to the read-only input image, and stale data is inverted on release.
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge mclk);
            reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            @(negedge mclk);
            reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask

    // One read; the registered answer is taken a half cycle after it lands.
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge mclk);
            reg_rd = 1'b1;
            reg_addr = a;
            @(negedge mclk);
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
endmodule

// ---- pmic_pin_and_buck_control_regs_tb.sv ----
`timescale 1ns/100ps
`include "pmic_ctrl_map.vh"
// Self-checking bench for the pin and buck control bank.
module pmic_pin_and_buck_control_regs_tb;
    localparam [119:0] ADDRS = {8'h0F, 8'h10, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
        8'h26, 8'h27, 8'h2B, 8'h2C, 8'h30, 8'h31, 8'h40};
    localparam [119:0] DFLT = {8'h03, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
    localparam [119:0] MASK = {8'hFF, 8'h0F, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h00};
    localparam [23:0] PULLS = {3'h3, 3'h4, 3'h2, 3'h4, 3'h1, 3'h0, 3'h0, 3'h0};
    reg mclk, rst_n, rtc_on, rtc_clk32;
    reg [95:0] base_image, exp_img;
    reg [11:0] fn123;
    reg [8:0] md123;
    reg [2:0] fl123;
    reg [3:0] pin_in;
    integer n_fail, total_checks, i, n;
    wire reg_wr, reg_rd, pu, pd, an, follower;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, linreg_on;
    wire [3:0] pin_out, pin_oe, buck_on, quiet, quick;
    wire [95:0] effective_image;
    wire [27:0] buck_level_out;
    wire [8:0] freq;

    pmic_host_model h (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    pmic_pin_and_buck_control_regs uut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .base_image(base_image), .pin123_function_select(fn123), .pin123_electrical_mode(md123),
        .pin123_polarity_flip(fl123), .rtc_on(rtc_on), .rtc_clk32(rtc_clk32), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin4_pull_up(pu), .pin4_pull_down(pd),
        .pin4_analog_en(an), .effective_image(effective_image), .buck_on(buck_on),
        .buck_level_out(buck_level_out), .linreg_on(linreg_on), .buck_quiet_mode(quiet),
        .buck_quick_regulation(quick), .buck3_follower(follower), .buck_freq_mhz(freq));

    // Free-running 200 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Compares one value and counts the outcome.
    task check(input logic [95:0] seen, input logic [95:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
            end
        end
    endtask
    task automatic rchk(input [7:0] a, input [7:0] e);
        logic [7:0] d;
        begin
            h.rd(a, d);
            check(d, e);
        end
    endtask
    task settle;
        repeat (3) @(negedge mclk);
    endtask
    task do_reset;
        begin
            rst_n = 1'b0;
            repeat (3) @(negedge mclk);
            rst_n = 1'b1;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d fails %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Waits a bounded time for the slow clock pin to change level.
    task automatic wait_flip(output integer cnt);
        logic v0;
        begin
            v0 = pin_out[3];
            cnt = 0;
            while (pin_out[3] === v0 && cnt < 3200) begin
                @(negedge mclk);
                cnt = cnt + 1;
            end
            if (cnt >= 3200) begin
                n_fail = n_fail + 1;
                final_report;
            end
        end
    endtask

    // Main sequence of tests.
    initial begin
        n_fail = 0;
        total_checks = 0;
        base_image = 96'h0;
        fn123 = 12'h000;
        md123 = 9'h000;
        fl123 = 3'h0;
        pin_in = 4'h0;
        rtc_on = 1'b0;
        rtc_clk32 = 1'b0;
        do_reset;
        for (i = 14; i >= 0; i = i - 1)
            rchk(ADDRS[8*i +: 8], DFLT[8*i +: 8]);
        check(freq, 9'h092);
        $display("reset values done");
        for (i = 14; i >= 0; i = i - 1) begin
            h.wr(ADDRS[8*i +: 8], MASK[8*i +: 8]);
            rchk(ADDRS[8*i +: 8], MASK[8*i +: 8]);
        end
        h.wr(8'h21, 8'h0F);
        rchk(8'h21, 8'h00);
        settle;
        check({quiet, quick, follower, freq}, {9'h1FF, 9'h0DB});
        base_image[7] = 1'b1;
        base_image[15] = 1'b1;
        base_image[23] = 1'b1;
        settle;
        check(freq, 9'h124);
        do_reset;
        settle;
        check({buck_on, freq}, {4'h0, 9'h0DB});
        $display("access test done");
        base_image = 96'h01010100;
        h.wr(8'h10, 8'h0B);
        settle;
        check(buck_on, 4'hA);
        h.wr(8'h25, 8'h04);
        settle;
        check(buck_on, 4'h8);
        pin_in[0] = 1'b1;
        settle;
        check(buck_on, 4'hA);
        base_image[47:32] = 16'h8080;
        h.wr(8'h26, 8'h02);
        settle;
        check(linreg_on, 8'h02);
        pin_in[1] = 1'b1;
        settle;
        check(linreg_on, 8'h03);
        fl123[1] = 1'b1;
        settle;
        check(linreg_on, 8'h02);
        $display("pin control test done");
        h.wr(8'h0F, 8'h01);
        h.wr(8'h20, 8'h08);
        settle;
        check({pin_out[3], pin_oe[3]}, 2'h3);
        h.wr(8'h0F, 8'h81);
        settle;
        check(pin_out[3], 1'b0);
        h.wr(8'h0F, 8'h02);
        settle;
        check(pin_oe[3], 1'b0);
        h.wr(8'h20, 8'h00);
        settle;
        check(pin_oe[3], 1'b1);
        pin_in[3] = 1'b1;
        h.wr(8'h0F, 8'h00);
        settle;
        rchk(8'h21, 8'h09);
        for (i = 0; i < 8; i = i + 1) begin
            h.wr(8'h0F, i[7:0]);
            settle;
            check({pu, pd, an}, PULLS[3*i +: 3]);
        end
        $display("pin four test done");
        base_image = 96'h0B0A09080706050403020100;
        pin_in[3] = 1'b0;
        h.wr(8'h0F, 8'h28);
        h.wr(8'h22, 8'hA1);
        h.wr(8'h23, 8'hA2);
        h.wr(8'h2B, 8'hA3);
        h.wr(8'h24, 8'h54);
        h.wr(8'h2C, 8'h06);
        settle;
        check(effective_image, base_image);
        pin_in[3] = 1'b1;
        exp_img = base_image;
        exp_img[55:32] = 24'hA3A2A1;
        settle;
        check(effective_image, exp_img);
        h.wr(8'h24, 8'h44);
        h.wr(8'h2C, 8'h04);
        exp_img = base_image;
        exp_img[39:32] = 8'hA3;
        settle;
        check(effective_image, exp_img);
        h.wr(8'h0F, 8'h30);
        h.wr(8'h24, 8'hBB);
        h.wr(8'h2C, 8'h0C);
        exp_img = base_image;
        exp_img[95:88] = 8'hA2;
        settle;
        check(effective_image, exp_img);
        $display("overlay test done");
        do_reset;
        base_image = 96'h01;
        settle;
        check(buck_level_out[6:0], 7'h01);
        h.wr(8'h31, 8'h10);
        base_image = 96'h0503;
        repeat (400) @(negedge mclk);
        check(buck_level_out[6:0], 7'h01);
        check(buck_level_out[13:7], 7'h05);
        repeat (800) @(negedge mclk);
        check(buck_level_out[6:0], 7'h02);
        repeat (900) @(negedge mclk);
        check(buck_level_out[6:0], 7'h03);
        h.wr(8'h31, 8'h08);
        settle;
        check({buck_on, buck_level_out[20:14]}, {4'h7, 7'h05});
        $display("ramp test done");
        h.wr(8'h0F, 8'h41);
        rtc_on = 1'b1;
        rtc_clk32 = 1'b1;
        repeat (6) @(negedge mclk);
        check(pin_out[3], 1'b1);
        rtc_clk32 = 1'b0;
        repeat (6) @(negedge mclk);
        check(pin_out[3], 1'b0);
        rtc_on = 1'b0;
        wait_flip(n);
        wait_flip(n);
        check(n, `SLOW_HALF_CYCLES);
        $display("slow clock test done");
        final_report;
    end
endmodule
